// ==== design/ecmb_bank.sv ====
// Mid slice of the extended card data byte array: fixed capability
// bytes and host configuration bytes, reached over a plain port.
// Assumes one clock, strobes one cycle long and never together.
// Assumes arst_n is the power-on reset, soft_reset a sync level.
// Read data and refusal pulses stand one cycle only.
//
// Summary of operation
// R1: DDR 52 MHz power classes 22/77
// R2: 200 MHz power classes both 88
// R3: SDR power classes 22 high, 66 low
// R4: DDR min read 50, write 00
// R5: Min read 64, 3c, 1e by mode
// R6: Four-byte sector count 00760000, read-only
// R7: Erase unit 08, erase timeout 07
// R8: Reliable write 01, protect group 01
// R9: Timeouts 0a, 10, 10
// R10: Partition switch 01, interrupt busy 0a
// R11: Secure caps 55, erase dc, trim ff
// R12: Device type 57, structure 02, revision 07
// R13: Boot_information 07, size 10, access 08
// R14: Erased content 00, secure protect 00
// R15: Bus width write-only, resets to zero
// R16: Timing, power, command set, group writable
// R17: Protect bytes mix plain and sticky bits
// R18: Boot protect status reads zero
// R19: Partition, boot bus, firmware bytes writable
// R20: Strobe support 00, driver caps 1f
// R21: Trim multiplier 01, flush policy 00
// R22: Reserved bytes read zero, ignore writes
// R23: Writes to read-only bytes ignored
//
// The address-and-strobe port was decided locally.

`timescale 1ns/100ps
`default_nettype none

module ecmb_bank (
	input  wire logic       clk,
	input  wire logic       arst_n,
	input  wire logic       soft_reset,
	input  wire logic [7:0] addr,
	input  wire logic [7:0] wdata,
	input  wire logic       wr,
	input  wire logic       rd,
	output logic      [7:0] rdata,
	output logic            write_refused,
	output logic      [7:0] firmware_config,
	output logic      [7:0] user_area_write_protect,
	output logic      [7:0] boot_area_write_protect,
	output logic      [7:0] erase_group_definition,
	output logic      [7:0] boot_bus_conditions,
	output logic      [7:0] boot_config_protection,
	output logic      [7:0] partition_configuration,
	output logic      [7:0] bus_width_select,
	output logic      [7:0] interface_timing_select,
	output logic      [7:0] power_class_select,
	output logic      [7:0] command_set_select
);

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	typedef struct packed {
		logic [7:0] rdata;
		logic       refused;
	} ecmb_bank_state_t;

	ecmb_bank_state_t state;
	ecmb_bank_state_t next_state;

	logic [ecmb_pkg::NCFG-1:0] wsel;
	logic [ecmb_pkg::NCFG-1:0] we;
	logic [7:0]                rd_mux;

	// ------------------------------------------------------------------
	// Write decode
	// ------------------------------------------------------------------
	ecmb_addr_class u_class (
		.addr (addr),
		.wsel (wsel)
	);

	assign we = wr ? wsel : '0; // [R22] [R23]

	// ------------------------------------------------------------------
	// Configuration bytes
	// ------------------------------------------------------------------
	ecmb_cfg_byte #(
		.WMASK   (ecmb_pkg::MASK_ALL),
		.STICKY  (ecmb_pkg::MASK_NONE),
		.SOFTCLR (ecmb_pkg::MASK_NONE)
	) u_fw (
		.clk        (clk),
		.arst_n     (arst_n),
		.wr_en      (we[ecmb_pkg::IDX_FW]), // [R19]
		.wdata      (wdata),
		.soft_clear (soft_reset),
		.value      (firmware_config)
	);

	ecmb_cfg_byte #(
		.WMASK   (ecmb_pkg::MASK_ALL),
		.STICKY  (ecmb_pkg::UWP_STICKY),
		.SOFTCLR (ecmb_pkg::MASK_NONE)
	) u_uwp (
		.clk        (clk),
		.arst_n     (arst_n),
		.wr_en      (we[ecmb_pkg::IDX_UWP]), // [R17]
		.wdata      (wdata),
		.soft_clear (soft_reset),
		.value      (user_area_write_protect)
	);

	ecmb_cfg_byte #(
		.WMASK   (ecmb_pkg::MASK_ALL),
		.STICKY  (ecmb_pkg::BWP_STICKY),
		.SOFTCLR (ecmb_pkg::MASK_NONE)
	) u_bwp (
		.clk        (clk),
		.arst_n     (arst_n),
		.wr_en      (we[ecmb_pkg::IDX_BWP]), // [R17]
		.wdata      (wdata),
		.soft_clear (soft_reset),
		.value      (boot_area_write_protect)
	);

	ecmb_cfg_byte #(
		.WMASK   (ecmb_pkg::MASK_ALL),
		.STICKY  (ecmb_pkg::MASK_NONE),
		.SOFTCLR (ecmb_pkg::MASK_NONE)
	) u_egd (
		.clk        (clk),
		.arst_n     (arst_n),
		.wr_en      (we[ecmb_pkg::IDX_EGD]), // [R16]
		.wdata      (wdata),
		.soft_clear (soft_reset),
		.value      (erase_group_definition)
	);

	ecmb_cfg_byte #(
		.WMASK   (ecmb_pkg::MASK_ALL),
		.STICKY  (ecmb_pkg::MASK_NONE),
		.SOFTCLR (ecmb_pkg::MASK_ALL)
	) u_bbc (
		.clk        (clk),
		.arst_n     (arst_n),
		.wr_en      (we[ecmb_pkg::IDX_BBC]), // [R19]
		.wdata      (wdata),
		.soft_clear (soft_reset),
		.value      (boot_bus_conditions)
	);

	ecmb_cfg_byte #(
		.WMASK   (ecmb_pkg::BCP_WMASK),
		.STICKY  (ecmb_pkg::BCP_STICKY),
		.SOFTCLR (ecmb_pkg::MASK_NONE)
	) u_bcp (
		.clk        (clk),
		.arst_n     (arst_n),
		.wr_en      (we[ecmb_pkg::IDX_BCP]),
		.wdata      (wdata),
		.soft_clear (soft_reset),
		.value      (boot_config_protection)
	);

	ecmb_cfg_byte #(
		.WMASK   (ecmb_pkg::MASK_ALL),
		.STICKY  (ecmb_pkg::MASK_NONE),
		.SOFTCLR (ecmb_pkg::PART_SOFTCLR)
	) u_part (
		.clk        (clk),
		.arst_n     (arst_n),
		.wr_en      (we[ecmb_pkg::IDX_PART]), // [R19]
		.wdata      (wdata),
		.soft_clear (soft_reset),
		.value      (partition_configuration)
	);

	ecmb_cfg_byte #(
		.WMASK   (ecmb_pkg::MASK_ALL),
		.STICKY  (ecmb_pkg::MASK_NONE),
		.SOFTCLR (ecmb_pkg::MASK_NONE)
	) u_busw (
		.clk        (clk),
		.arst_n     (arst_n),
		.wr_en      (we[ecmb_pkg::IDX_BUSW]), // [R15]
		.wdata      (wdata),
		.soft_clear (soft_reset),
		.value      (bus_width_select)
	);

	ecmb_cfg_byte #(
		.WMASK   (ecmb_pkg::MASK_ALL),
		.STICKY  (ecmb_pkg::MASK_NONE),
		.SOFTCLR (ecmb_pkg::MASK_NONE)
	) u_tim (
		.clk        (clk),
		.arst_n     (arst_n),
		.wr_en      (we[ecmb_pkg::IDX_TIM]), // [R16]
		.wdata      (wdata),
		.soft_clear (soft_reset),
		.value      (interface_timing_select)
	);

	ecmb_cfg_byte #(
		.WMASK   (ecmb_pkg::MASK_ALL),
		.STICKY  (ecmb_pkg::MASK_NONE),
		.SOFTCLR (ecmb_pkg::MASK_NONE)
	) u_pwr (
		.clk        (clk),
		.arst_n     (arst_n),
		.wr_en      (we[ecmb_pkg::IDX_PWR]), // [R16]
		.wdata      (wdata),
		.soft_clear (soft_reset),
		.value      (power_class_select)
	);

	ecmb_cfg_byte #(
		.WMASK   (ecmb_pkg::MASK_ALL),
		.STICKY  (ecmb_pkg::MASK_NONE),
		.SOFTCLR (ecmb_pkg::MASK_NONE)
	) u_cset (
		.clk        (clk),
		.arst_n     (arst_n),
		.wr_en      (we[ecmb_pkg::IDX_CSET]), // [R16]
		.wdata      (wdata),
		.soft_clear (soft_reset),
		.value      (command_set_select)
	);

	// ------------------------------------------------------------------
	// Read multiplexer
	// ------------------------------------------------------------------
	always_comb begin
		rd_mux = ecmb_pkg::VAL_RESERVED;
		case (addr)
			ecmb_pkg::OFS_FLUSH_POL: rd_mux = ecmb_pkg::VAL_FLUSH_POL; // [R21]

			ecmb_pkg::OFS_PC_DDR52_HI: rd_mux = ecmb_pkg::VAL_PC_DDR52_HI; // [R1]
			ecmb_pkg::OFS_PC_DDR52_LO: rd_mux = ecmb_pkg::VAL_PC_DDR52_LO; // [R1]

			ecmb_pkg::OFS_PC200_195: rd_mux = ecmb_pkg::VAL_PC200_195; // [R2]
			ecmb_pkg::OFS_PC200_130: rd_mux = ecmb_pkg::VAL_PC200_130; // [R2]

			ecmb_pkg::OFS_MINW_DDR: rd_mux = ecmb_pkg::VAL_MINW_DDR; // [R4]
			ecmb_pkg::OFS_MINR_DDR: rd_mux = ecmb_pkg::VAL_MINR_DDR; // [R4]

			ecmb_pkg::OFS_TRIM_MUL: rd_mux = ecmb_pkg::VAL_TRIM_MUL; // [R21]

			ecmb_pkg::OFS_SEC_FEAT: rd_mux = ecmb_pkg::VAL_SEC_FEAT; // [R11]
			ecmb_pkg::OFS_SEC_ERM: rd_mux = ecmb_pkg::VAL_SEC_ERM; // [R11]
			ecmb_pkg::OFS_SEC_TRM: rd_mux = ecmb_pkg::VAL_SEC_TRM; // [R11]

			ecmb_pkg::OFS_BOOT_INF: rd_mux = ecmb_pkg::VAL_BOOT_INF; // [R13]
			ecmb_pkg::OFS_BOOT_SZ: rd_mux = ecmb_pkg::VAL_BOOT_SZ; // [R13]
			ecmb_pkg::OFS_ACCESS: rd_mux = ecmb_pkg::VAL_ACCESS; // [R13]

			ecmb_pkg::OFS_ERU: rd_mux = ecmb_pkg::VAL_ERU; // [R7]
			ecmb_pkg::OFS_ER_TMO: rd_mux = ecmb_pkg::VAL_ER_TMO; // [R7]

			ecmb_pkg::OFS_RELW: rd_mux = ecmb_pkg::VAL_RELW; // [R8]
			ecmb_pkg::OFS_WPG: rd_mux = ecmb_pkg::VAL_WPG; // [R8]

			ecmb_pkg::OFS_SLP_CORE: rd_mux = ecmb_pkg::VAL_SLP_CORE;
			ecmb_pkg::OFS_SLP_IO: rd_mux = ecmb_pkg::VAL_SLP_IO;

			ecmb_pkg::OFS_PROD_TMO: rd_mux = ecmb_pkg::VAL_PROD_TMO; // [R9]
			ecmb_pkg::OFS_SLP_AWK: rd_mux = ecmb_pkg::VAL_SLP_AWK; // [R9]
			ecmb_pkg::OFS_SLP_NTF: rd_mux = ecmb_pkg::VAL_SLP_NTF; // [R9]

			ecmb_pkg::OFS_SECT_B3: rd_mux = ecmb_pkg::VAL_SECTORS[31:24]; // [R6]
			ecmb_pkg::OFS_SECT_B2: rd_mux = ecmb_pkg::VAL_SECTORS[23:16]; // [R6]
			ecmb_pkg::OFS_SECT_B1: rd_mux = ecmb_pkg::VAL_SECTORS[15:8]; // [R6]
			ecmb_pkg::OFS_SECT_B0: rd_mux = ecmb_pkg::VAL_SECTORS[7:0]; // [R6]

			ecmb_pkg::OFS_SWP_INF: rd_mux = ecmb_pkg::VAL_SWP_INF; // [R14]

			ecmb_pkg::OFS_MINW_W52: rd_mux = ecmb_pkg::VAL_MINW_W52;
			ecmb_pkg::OFS_MINR_W52: rd_mux = ecmb_pkg::VAL_MINR_W52; // [R5]

			ecmb_pkg::OFS_MINW_MID: rd_mux = ecmb_pkg::VAL_MINW_MID;
			ecmb_pkg::OFS_MINR_MID: rd_mux = ecmb_pkg::VAL_MINR_MID; // [R5]

			ecmb_pkg::OFS_MINW_N26: rd_mux = ecmb_pkg::VAL_MINW_N26;
			ecmb_pkg::OFS_MINR_N26: rd_mux = ecmb_pkg::VAL_MINR_N26; // [R5]

			ecmb_pkg::OFS_PC26_HI: rd_mux = ecmb_pkg::VAL_PC26_HI; // [R3]
			ecmb_pkg::OFS_PC52_HI: rd_mux = ecmb_pkg::VAL_PC52_HI; // [R3]
			ecmb_pkg::OFS_PC26_LO: rd_mux = ecmb_pkg::VAL_PC26_LO; // [R3]
			ecmb_pkg::OFS_PC52_LO: rd_mux = ecmb_pkg::VAL_PC52_LO; // [R3]

			ecmb_pkg::OFS_PSW_TIME: rd_mux = ecmb_pkg::VAL_PSW_TIME; // [R10]
			ecmb_pkg::OFS_IRQ_BUSY: rd_mux = ecmb_pkg::VAL_IRQ_BUSY; // [R10]

			ecmb_pkg::OFS_DRV_CAPS: rd_mux = ecmb_pkg::VAL_DRV_CAPS; // [R20]
			ecmb_pkg::OFS_DEV_TYPE: rd_mux = ecmb_pkg::VAL_DEV_TYPE; // [R12]
			ecmb_pkg::OFS_STRUCT_V: rd_mux = ecmb_pkg::VAL_STRUCT_V; // [R12]
			ecmb_pkg::OFS_EXT_REV: rd_mux = ecmb_pkg::VAL_EXT_REV; // [R12]

			ecmb_pkg::OFS_CSET_REV: rd_mux = ecmb_pkg::VAL_CSET_REV;
			ecmb_pkg::OFS_STROBE: rd_mux = ecmb_pkg::VAL_STROBE; // [R20]
			ecmb_pkg::OFS_ERASED: rd_mux = ecmb_pkg::VAL_ERASED; // [R14]
			ecmb_pkg::OFS_BOOT_STS: rd_mux = ecmb_pkg::VAL_BOOT_STS; // [R18]

			// Writable bytes read back their state, except bus width, which reads zero
			ecmb_pkg::OFS_FW: rd_mux = firmware_config;
			ecmb_pkg::OFS_UWP: rd_mux = user_area_write_protect;
			ecmb_pkg::OFS_BWP: rd_mux = boot_area_write_protect;
			ecmb_pkg::OFS_EGD: rd_mux = erase_group_definition;
			ecmb_pkg::OFS_BBC: rd_mux = boot_bus_conditions;
			ecmb_pkg::OFS_BCP: rd_mux = boot_config_protection;
			ecmb_pkg::OFS_PART: rd_mux = partition_configuration;
			ecmb_pkg::OFS_BUSW: rd_mux = ecmb_pkg::VAL_RESERVED; // [R15]
			ecmb_pkg::OFS_TIM: rd_mux = interface_timing_select;
			ecmb_pkg::OFS_PWR: rd_mux = power_class_select;
			ecmb_pkg::OFS_CSET: rd_mux = command_set_select;

			default: rd_mux = ecmb_pkg::VAL_RESERVED; // [R22]
		endcase
	end

	// ------------------------------------------------------------------
	// Answer registers
	// ------------------------------------------------------------------
	always_comb begin
		next_state = state;
		next_state.rdata = rd ? rd_mux : ecmb_pkg::RDATA_IDLE;
		next_state.refused = wr && (wsel == '0); // [R23]
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state.rdata <= ecmb_pkg::RDATA_IDLE;
			state.refused <= 1'b0;
		end else begin
			state <= next_state;
		end
	end

	assign rdata = state.rdata;
	assign write_refused = state.refused;
endmodule : ecmb_bank
`default_nettype wire

// ==== inc/ecmb_pkg.sv ====
// Byte offsets, fixed values and bit masks of the mid slice of the
// extended card data array.
// Assumes the bank is addressed by byte index, one byte per access.
`default_nettype none
package ecmb_pkg;
	// ------------------------------------------------------------------
	// Writable bytes
	// ------------------------------------------------------------------
	localparam int NCFG = 11;
	localparam int IDX_FW = 0, IDX_UWP = 1, IDX_BWP = 2, IDX_EGD = 3;
	localparam int IDX_BBC = 4, IDX_BCP = 5, IDX_PART = 6, IDX_BUSW = 7;
	localparam int IDX_TIM = 8, IDX_PWR = 9, IDX_CSET = 10;
	localparam logic [7:0] OFS_FW = 8'ha9, OFS_UWP = 8'hab, OFS_BWP = 8'had;
	localparam logic [7:0] OFS_EGD = 8'haf, OFS_BBC = 8'hb1, OFS_BCP = 8'hb2;
	localparam logic [7:0] OFS_PART = 8'hb3, OFS_BUSW = 8'hb7, OFS_TIM = 8'hb9;
	localparam logic [7:0] OFS_PWR = 8'hbb, OFS_CSET = 8'hbf;
	localparam logic [7:0] CFG_RESET = 8'h00;
	localparam logic [7:0] MASK_ALL = 8'hff, MASK_NONE = 8'h00;
	localparam logic [7:0] BCP_WMASK = 8'h11, BCP_STICKY = 8'h01;
	localparam logic [7:0] UWP_STICKY = 8'h14, BWP_STICKY = 8'h05;
	localparam logic [7:0] PART_SOFTCLR = 8'h78;
	// ------------------------------------------------------------------
	// Read-only bytes: offset and fixed value
	// ------------------------------------------------------------------
	localparam logic [7:0] OFS_FLUSH_POL = 8'hf0, VAL_FLUSH_POL = 8'h00;
	localparam logic [7:0] OFS_PC_DDR52_HI = 8'hef, VAL_PC_DDR52_HI = 8'h22;
	localparam logic [7:0] OFS_PC_DDR52_LO = 8'hee, VAL_PC_DDR52_LO = 8'h77;
	localparam logic [7:0] OFS_PC200_195 = 8'hed, VAL_PC200_195 = 8'h88;
	localparam logic [7:0] OFS_PC200_130 = 8'hec, VAL_PC200_130 = 8'h88;
	localparam logic [7:0] OFS_MINW_DDR = 8'heb, VAL_MINW_DDR = 8'h00;
	localparam logic [7:0] OFS_MINR_DDR = 8'hea, VAL_MINR_DDR = 8'h50;
	localparam logic [7:0] OFS_TRIM_MUL = 8'he8, VAL_TRIM_MUL = 8'h01;
	localparam logic [7:0] OFS_SEC_FEAT = 8'he7, VAL_SEC_FEAT = 8'h55;
	localparam logic [7:0] OFS_SEC_ERM = 8'he6, VAL_SEC_ERM = 8'hdc;
	localparam logic [7:0] OFS_SEC_TRM = 8'he5, VAL_SEC_TRM = 8'hff;
	localparam logic [7:0] OFS_BOOT_INF = 8'he4, VAL_BOOT_INF = 8'h07;
	localparam logic [7:0] OFS_BOOT_SZ = 8'he2, VAL_BOOT_SZ = 8'h10;
	localparam logic [7:0] OFS_ACCESS = 8'he1, VAL_ACCESS = 8'h08;
	localparam logic [7:0] OFS_ERU = 8'he0, VAL_ERU = 8'h08;
	localparam logic [7:0] OFS_ER_TMO = 8'hdf, VAL_ER_TMO = 8'h07;
	localparam logic [7:0] OFS_RELW = 8'hde, VAL_RELW = 8'h01;
	localparam logic [7:0] OFS_WPG = 8'hdd, VAL_WPG = 8'h01;
	localparam logic [7:0] OFS_SLP_CORE = 8'hdc, VAL_SLP_CORE = 8'h06;
	localparam logic [7:0] OFS_SLP_IO = 8'hdb, VAL_SLP_IO = 8'h0a;
	localparam logic [7:0] OFS_PROD_TMO = 8'hda, VAL_PROD_TMO = 8'h0a;
	localparam logic [7:0] OFS_SLP_AWK = 8'hd9, VAL_SLP_AWK = 8'h10;
	localparam logic [7:0] OFS_SLP_NTF = 8'hd8, VAL_SLP_NTF = 8'h10;
	localparam logic [7:0] OFS_SECT_B3 = 8'hd7, OFS_SECT_B2 = 8'hd6;
	localparam logic [7:0] OFS_SECT_B1 = 8'hd5, OFS_SECT_B0 = 8'hd4;
	localparam logic [31:0] VAL_SECTORS = 32'h00760000;
	localparam logic [7:0] OFS_SWP_INF = 8'hd3, VAL_SWP_INF = 8'h00;
	localparam logic [7:0] OFS_MINW_W52 = 8'hd2, VAL_MINW_W52 = 8'h00;
	localparam logic [7:0] OFS_MINR_W52 = 8'hd1, VAL_MINR_W52 = 8'h64;
	localparam logic [7:0] OFS_MINW_MID = 8'hd0, VAL_MINW_MID = 8'h00;
	localparam logic [7:0] OFS_MINR_MID = 8'hcf, VAL_MINR_MID = 8'h3c;
	localparam logic [7:0] OFS_MINW_N26 = 8'hce, VAL_MINW_N26 = 8'h00;
	localparam logic [7:0] OFS_MINR_N26 = 8'hcd, VAL_MINR_N26 = 8'h1e;
	localparam logic [7:0] OFS_PC26_HI = 8'hcb, VAL_PC26_HI = 8'h22;
	localparam logic [7:0] OFS_PC52_HI = 8'hca, VAL_PC52_HI = 8'h22;
	localparam logic [7:0] OFS_PC26_LO = 8'hc9, VAL_PC26_LO = 8'h66;
	localparam logic [7:0] OFS_PC52_LO = 8'hc8, VAL_PC52_LO = 8'h66;
	localparam logic [7:0] OFS_PSW_TIME = 8'hc7, VAL_PSW_TIME = 8'h01;
	localparam logic [7:0] OFS_IRQ_BUSY = 8'hc6, VAL_IRQ_BUSY = 8'h0a;
	localparam logic [7:0] OFS_DRV_CAPS = 8'hc5, VAL_DRV_CAPS = 8'h1f;
	localparam logic [7:0] OFS_DEV_TYPE = 8'hc4, VAL_DEV_TYPE = 8'h57;
	localparam logic [7:0] OFS_STRUCT_V = 8'hc2, VAL_STRUCT_V = 8'h02;
	localparam logic [7:0] OFS_EXT_REV = 8'hc0, VAL_EXT_REV = 8'h07;
	localparam logic [7:0] OFS_CSET_REV = 8'hbd, VAL_CSET_REV = 8'h00;
	localparam logic [7:0] OFS_STROBE = 8'hb8, VAL_STROBE = 8'h00;
	localparam logic [7:0] OFS_ERASED = 8'hb5, VAL_ERASED = 8'h00;
	localparam logic [7:0] OFS_BOOT_STS = 8'hae, VAL_BOOT_STS = 8'h00;
	localparam logic [7:0] VAL_RESERVED = 8'h00;
	localparam logic [7:0] RDATA_IDLE = 8'h00;
endpackage : ecmb_pkg
`default_nettype wire

// ==== design/ecmb_cfg_byte.sv ====
// One host-writable configuration byte with per-bit write, sticky
// and soft-clear masks.
// Assumes arst_n is the power-on reset of the bank.
`timescale 1ns/100ps
`default_nettype none
module ecmb_cfg_byte #(
	parameter logic [7:0] WMASK   = 8'hff,
	parameter logic [7:0] STICKY  = 8'h00,
	parameter logic [7:0] SOFTCLR = 8'h00
) (
	input  wire logic       clk,
	input  wire logic       arst_n,
	input  wire logic       wr_en,
	input  wire logic [7:0] wdata,
	input  wire logic       soft_clear,
	output logic      [7:0] value
);
	typedef struct packed {
		logic [7:0] value;
	} ecmb_cfg_state_t;
	ecmb_cfg_state_t state;
	ecmb_cfg_state_t next_state;
	// ------------------------------------------------------------------
	// Next value
	// ------------------------------------------------------------------
	always_comb begin
		next_state = state;
		if (soft_clear) begin
			next_state.value = state.value & ~SOFTCLR;
		end
		if (wr_en) begin
			// Sticky bits only set; plain bits take the data
			next_state.value = (next_state.value & ~WMASK)
				| (wdata & WMASK & ~STICKY)
				| ((next_state.value | wdata) & WMASK & STICKY);
		end
	end
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state.value <= ecmb_pkg::CFG_RESET;
		end else begin
			state <= next_state;
		end
	end
	assign value = state.value;
endmodule : ecmb_cfg_byte
`default_nettype wire

// ==== design/ecmb_addr_class.sv ====
// Decoder from byte index to one-hot select of the writable bytes.
// Assumes a byte index on addr; anything else selects nothing.
`timescale 1ns/100ps
`default_nettype none
module ecmb_addr_class (
	input  wire logic [7:0]                addr,
	output logic      [ecmb_pkg::NCFG-1:0] wsel
);
	// ------------------------------------------------------------------
	// Decode
	// ------------------------------------------------------------------
	always_comb begin
		wsel = '0;
		case (addr)
			ecmb_pkg::OFS_FW: wsel[ecmb_pkg::IDX_FW] = 1'b1;
			ecmb_pkg::OFS_UWP: wsel[ecmb_pkg::IDX_UWP] = 1'b1;
			ecmb_pkg::OFS_BWP: wsel[ecmb_pkg::IDX_BWP] = 1'b1;
			ecmb_pkg::OFS_EGD: wsel[ecmb_pkg::IDX_EGD] = 1'b1;
			ecmb_pkg::OFS_BBC: wsel[ecmb_pkg::IDX_BBC] = 1'b1;
			ecmb_pkg::OFS_BCP: wsel[ecmb_pkg::IDX_BCP] = 1'b1;
			ecmb_pkg::OFS_PART: wsel[ecmb_pkg::IDX_PART] = 1'b1;
			ecmb_pkg::OFS_BUSW: wsel[ecmb_pkg::IDX_BUSW] = 1'b1;
			ecmb_pkg::OFS_TIM: wsel[ecmb_pkg::IDX_TIM] = 1'b1;
			ecmb_pkg::OFS_PWR: wsel[ecmb_pkg::IDX_PWR] = 1'b1;
			ecmb_pkg::OFS_CSET: wsel[ecmb_pkg::IDX_CSET] = 1'b1;
			default: wsel = '0;
		endcase
	end
endmodule : ecmb_addr_class
`default_nettype wire

// ==== test/ecmb_host_model.sv ====
// Host controller model on the register port of the bank.
// Assumes read data one cycle after the read strobe, no wait states.
`timescale 1ns/100ps
`default_nettype none
module ecmb_host_model (
	input  wire logic       clk,
	output logic      [7:0] addr,
	output logic      [7:0] wdata,
	output logic            wr,
	output logic            rd,
	input  wire logic [7:0] rdata,
	input  wire logic       write_refused
);
	// ------------------------------------------------------------------
	// Bus cycles
	// ------------------------------------------------------------------
	initial begin
		addr = 8'h00;
		wdata = 8'h00;
		wr = 1'b0;
		rd = 1'b0;
	end

	// Host selects settings by writing bytes
	task automatic put_byte(input logic [7:0] a, input logic [7:0] d, output logic refused);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		#1;
		refused = write_refused;
	endtask : put_byte

	task automatic get_byte(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		d = rdata;
	endtask : get_byte
endmodule : ecmb_host_model
`default_nettype wire

// ==== test/ecmb_bank_monitor.sv ====
// Checker on the ports of the bank.
// Assumes a single clock domain and the async power-on reset.
`timescale 1ns/100ps
`default_nettype none
module ecmb_bank_monitor (
	input wire logic       clk,
	input wire logic       arst_n,
	input wire logic       soft_reset,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic       wr,
	input wire logic       rd,
	input wire logic [7:0] rdata,
	input wire logic       write_refused,
	input wire logic [7:0] user_area_write_protect,
	input wire logic [7:0] boot_bus_conditions,
	input wire logic [7:0] bus_width_select,
	input wire logic [7:0] interface_timing_select
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);
	// ------------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------------
	chk_ddr_power_class: assert property (rd && addr == 8'hef |=> rdata == 8'h22)
		else $error("ddr power class read wrong");
	chk_device_type: assert property (rd && addr == 8'hc4 |=> rdata == 8'h57)
		else $error("device type read wrong");
	chk_sector_byte: assert property (rd && addr == 8'hd6 |=> rdata == 8'h76)
		else $error("sector count byte read wrong");
	chk_ro_refused: assert property (wr && addr == 8'hc4 |=> write_refused)
		else $error("read-only write not refused");
	chk_reserved_zero: assert property (rd && (addr == 8'he9 || addr == 8'he3) |=> rdata == 8'h00)
		else $error("reserved byte not zero");
	chk_timing_write: assert property (wr && addr == 8'hb9 |=>
		!write_refused && interface_timing_select == $past(wdata))
		else $error("timing byte write lost");
	chk_timing_hold: assert property (!(wr && addr == 8'hb9) |=> $stable(interface_timing_select))
		else $error("timing byte changed without write");
	chk_width_hidden: assert property (rd && addr == 8'hb7 |=> rdata == 8'h00)
		else $error("bus width byte readable");
	chk_width_write: assert property (wr && addr == 8'hb7 |=> bus_width_select == $past(wdata, 1))
		else $error("bus width write lost");
	chk_user_sticky: assert property (wr && addr == 8'hab |=>
		(user_area_write_protect & 8'h14) == (($past(user_area_write_protect) | $past(wdata)) & 8'h14))
		else $error("user protect sticky bits wrong");
	chk_soft_clear: assert property (soft_reset && !wr |=> boot_bus_conditions == 8'h00)
		else $error("boot bus byte not cleared");
endmodule : ecmb_bank_monitor
bind ecmb_bank ecmb_bank_monitor mon_u (.clk(clk), .arst_n(arst_n), .soft_reset(soft_reset), .addr(addr),
	.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .write_refused(write_refused),
	.user_area_write_protect(user_area_write_protect), .boot_bus_conditions(boot_bus_conditions),
	.bus_width_select(bus_width_select), .interface_timing_select(interface_timing_select));
`default_nettype wire

// ==== test/ecmb_bank_test.sv ====
// Self-checking bench of the bank with a host model on its port.
// Assumes 20 MHz clock and reset held 6 cycles at start.
`timescale 1ns/100ps
`default_nettype none
`define ECMB_CHK(what, exp, got) begin check_count++; if ((got) !== (exp)) begin err_total++; \
	$display("Error %s expected %h seen %h", what, exp, got); end end
module ecmb_bank_test;
	logic       clk, arst_n, soft_reset, wr, rd, write_refused, rf;
	logic [7:0] addr, wdata, rdata, d;
	logic [7:0] cfg_o [0:10];
	int         err_total = 0, check_count = 0;
	localparam logic [7:0] CFG_OFS [0:10] = '{8'ha9, 8'hab, 8'had, 8'haf, 8'hb1, 8'hb2, 8'hb3, 8'hb7,
		8'hb9, 8'hbb, 8'hbf};
	localparam logic [7:0] EXP_FF [0:10] = '{8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h11, 8'hff, 8'hff,
		8'hff, 8'hff, 8'hff};
	localparam logic [7:0] EXP_00 [0:10] = '{8'h00, 8'h14, 8'h05, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00,
		8'h00, 8'h00, 8'h00};
	localparam logic [15:0] RO_TAB [0:47] = '{16'hf000, 16'hef22, 16'hee77, 16'hed88, 16'hec88, 16'heb00,
		16'hea50, 16'he801, 16'he755, 16'he6dc, 16'he5ff, 16'he407, 16'he210, 16'he108, 16'he008, 16'hdf07,
		16'hde01, 16'hdd01, 16'hdc06, 16'hdb0a, 16'hda0a, 16'hd910, 16'hd810, 16'hd700, 16'hd676, 16'hd500,
		16'hd400, 16'hd300, 16'hd200, 16'hd164, 16'hd000, 16'hcf3c, 16'hce00, 16'hcd1e, 16'hcb22, 16'hca22,
		16'hc966, 16'hc866, 16'hc701, 16'hc60a, 16'hc51f, 16'hc457, 16'hc202, 16'hc007, 16'hbd00, 16'hb800,
		16'hb500, 16'hae00};
	localparam logic [7:0] RSV [0:16] = '{8'he9, 8'he3, 8'hcc, 8'hc3, 8'hc1, 8'hbe, 8'hbc, 8'hba, 8'hb6,
		8'hb4, 8'hb0, 8'hac, 8'haa, 8'ha8, 8'hf1, 8'h00, 8'hff};
	// ------------------------------------------------------------------
	// Design and host
	// ------------------------------------------------------------------
	ecmb_bank dut_u (.clk(clk), .arst_n(arst_n), .soft_reset(soft_reset), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd), .rdata(rdata), .write_refused(write_refused), .firmware_config(cfg_o[0]),
		.user_area_write_protect(cfg_o[1]), .boot_area_write_protect(cfg_o[2]),
		.erase_group_definition(cfg_o[3]), .boot_bus_conditions(cfg_o[4]), .boot_config_protection(cfg_o[5]),
		.partition_configuration(cfg_o[6]), .bus_width_select(cfg_o[7]), .interface_timing_select(cfg_o[8]),
		.power_class_select(cfg_o[9]), .command_set_select(cfg_o[10]));
	ecmb_host_model host_u (.clk(clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
		.write_refused(write_refused));
	// ------------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------------
	task automatic t_read_only();
		for (int i = 0; i < 48; i++) begin
			host_u.get_byte(RO_TAB[i][15:8], d);
			`ECMB_CHK("fixed byte", RO_TAB[i][7:0], d)
			host_u.put_byte(RO_TAB[i][15:8], ~RO_TAB[i][7:0], rf);
			`ECMB_CHK("fixed refused", 1'b1, rf)
			host_u.get_byte(RO_TAB[i][15:8], d);
			`ECMB_CHK("fixed kept", RO_TAB[i][7:0], d)
		end
	endtask : t_read_only

	task automatic t_reserved();
		for (int i = 0; i < 17; i++) begin
			host_u.put_byte(RSV[i], 8'ha5, rf);
			`ECMB_CHK("reserved refused", 1'b1, rf)
			host_u.get_byte(RSV[i], d);
			`ECMB_CHK("reserved zero", 8'h00, d)
		end
	endtask : t_reserved

	task automatic t_config(input logic [7:0] v, input logic [7:0] exp [0:10]);
		for (int i = 0; i < 11; i++) begin
			host_u.put_byte(CFG_OFS[i], v, rf);
			`ECMB_CHK("config accepted", 1'b0, rf)
			`ECMB_CHK("config port", exp[i], cfg_o[i])
			host_u.get_byte(CFG_OFS[i], d);
			`ECMB_CHK("config read", (i == 7) ? 8'h00 : exp[i], d)
		end
	endtask : t_config

	task automatic t_soft_clear();
		host_u.put_byte(8'hb1, 8'hff, rf);
		host_u.put_byte(8'hb3, 8'hff, rf);
		@(posedge clk);
		soft_reset <= 1'b1;
		@(posedge clk);
		soft_reset <= 1'b0;
		#1;
		`ECMB_CHK("boot bus cleared", 8'h00, cfg_o[4])
		`ECMB_CHK("partition kept", 8'h87, cfg_o[6])
	endtask : t_soft_clear

	task automatic t_power_on();
		host_u.put_byte(8'hab, 8'hff, rf);
		`ECMB_CHK("protect set", 8'hff, cfg_o[1])
		@(posedge clk);
		arst_n <= 1'b0;
		repeat (2) @(posedge clk);
		arst_n <= 1'b1;
		for (int i = 0; i < 11; i++) begin
			`ECMB_CHK("power-on zero", 8'h00, cfg_o[i])
		end
	endtask : t_power_on

	task automatic summarize();
		$display("Checks %0d errors %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : summarize
	// ------------------------------------------------------------------
	// Clock, reset, sequence, watchdog
	// ------------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	initial begin
		arst_n = 1'b0;
		soft_reset = 1'b0;
		repeat (6) @(posedge clk);
		arst_n <= 1'b1;
		t_power_on();
		t_read_only();
		t_reserved();
		t_config(8'hff, EXP_FF);
		t_config(8'h00, EXP_00);
		t_soft_clear();
		t_power_on();
		summarize();
	end

	initial begin
		#(5000 * 50);
		err_total++;
		summarize();
	end
endmodule : ecmb_bank_test
`default_nettype wire
